/* File: inc/pbc_pkg.sv */
package pbc_pkg;

  // Select codes for port B bit 6
  localparam logic [1:0] SEL_B6_GPIO = 2'h0;
  localparam logic [1:0] SEL_B6_RX   = 2'h1;
  localparam logic [1:0] SEL_B6_SDA  = 2'h2;
  localparam logic [1:0] SEL_B6_CLK  = 2'h3;

  // Select codes for port B bit 7
  localparam logic [1:0] SEL_B7_GPIO = 2'h0;
  localparam logic [1:0] SEL_B7_TX   = 2'h1;
  localparam logic [1:0] SEL_B7_SCL  = 2'h2;

  // Select codes for port C analog pads (bits 2, 4, 6)
  localparam logic [1:0] SEL_C_GPIO  = 2'h0;
  localparam logic [1:0] SEL_C_FIRST = 2'h1;
  localparam logic [1:0] SEL_C_SECOND = 2'h2;

  // Select field reset value: every pad starts as general-purpose I/O
  localparam logic [1:0] SEL_RESET   = 2'h0;

  // Test-port soft reset: TMS high on this many rising TCK edges
  localparam logic [2:0] TAP_RESET_EDGES = 3'h5;

  // Test-port controller states, one-hot
  typedef enum logic [15:0] {
    PBC_TLR  = 16'h0001, PBC_RTI  = 16'h0002, PBC_SDR  = 16'h0004, PBC_CDR  = 16'h0008,
    PBC_SHDR = 16'h0010, PBC_E1DR = 16'h0020, PBC_PDR  = 16'h0040, PBC_E2DR = 16'h0080,
    PBC_UDR  = 16'h0100, PBC_SIR  = 16'h0200, PBC_CIR  = 16'h0400, PBC_SHIR = 16'h0800,
    PBC_E1IR = 16'h1000, PBC_PIR  = 16'h2000, PBC_E2IR = 16'h4000, PBC_UIR  = 16'h8000
  } pbc_tap_e;

endpackage

/* File: hdl/pbc_tap_fsm.sv */
module pbc_tap_fsm
  import pbc_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   srst,
  input  wire logic   tck_rise,
  input  wire logic   tms,
  output pbc_tap_e    state
);

  pbc_tap_e next_state;

  // Standard test-port state walk; TMS high always drifts toward TLR
  always_comb
  begin
    next_state = state;
    if (tck_rise)
    begin
      case (state)
        PBC_TLR:  next_state = tms ? PBC_TLR  : PBC_RTI;
        PBC_RTI:  next_state = tms ? PBC_SDR  : PBC_RTI;
        PBC_SDR:  next_state = tms ? PBC_SIR  : PBC_CDR;
        PBC_CDR:  next_state = tms ? PBC_E1DR : PBC_SHDR;
        PBC_SHDR: next_state = tms ? PBC_E1DR : PBC_SHDR;
        PBC_E1DR: next_state = tms ? PBC_UDR  : PBC_PDR;
        PBC_PDR:  next_state = tms ? PBC_E2DR : PBC_PDR;
        PBC_E2DR: next_state = tms ? PBC_UDR  : PBC_SHDR;
        PBC_UDR:  next_state = tms ? PBC_SDR  : PBC_RTI;
        PBC_SIR:  next_state = tms ? PBC_TLR  : PBC_CIR;
        PBC_CIR:  next_state = tms ? PBC_E1IR : PBC_SHIR;
        PBC_SHIR: next_state = tms ? PBC_E1IR : PBC_SHIR;
        PBC_E1IR: next_state = tms ? PBC_UIR  : PBC_PIR;
        PBC_PIR:  next_state = tms ? PBC_E2IR : PBC_PIR;
        PBC_E2IR: next_state = tms ? PBC_UIR  : PBC_SHIR;
        PBC_UIR:  next_state = tms ? PBC_SDR  : PBC_RTI;
        default:  next_state = PBC_TLR;
      endcase
    end
  end

  // Power-on reset forces TLR
  always_ff @(posedge clock)
  begin
    if (srst)
      state <= PBC_TLR;
    else
      state <= next_state;
  end

endmodule

/* File: hdl/pbc_pin_mux.sv */
// Contract
// - Port B bit6: receive, data or clock
// - Clock input needs clock-module enable too
// - Port B bit7: transmit or clock line
// - Port C bit2: A input2 or A reference
// - Port C bit4: B input0 or comparator
// - Port C bit6: B input2 or B reference
// - No test reset pin; held inactive
// - Power-on reset forces test port reset
// - Five TMS-high TCK edges reset test port
module pbc_pin_mux
  import pbc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  // Peripheral select fields
  input  wire logic [1:0]  sel_b6,
  input  wire logic [1:0]  sel_b7,
  input  wire logic [1:0]  sel_c2,
  input  wire logic [1:0]  sel_c4,
  input  wire logic [1:0]  sel_c6,
  input  wire logic        pll_external_clock_input_enable,
  // Pad B6
  input  wire logic        port_b_bit6_in,
  output logic             port_b_bit6_out,
  output logic             port_b_bit6_oe,
  output logic             port_b_bit6_an,
  // Pad B7
  input  wire logic        port_b_bit7_in,
  output logic             port_b_bit7_out,
  output logic             port_b_bit7_oe,
  // Port C pads: analog path switch per pad
  output logic             port_c_bit2_an,
  output logic             port_c_bit4_an,
  output logic             port_c_bit6_an,
  // General-purpose I/O side
  input  wire logic        gpio_b6_out,
  input  wire logic        gpio_b6_oe,
  output logic             gpio_b6_in,
  input  wire logic        gpio_b7_out,
  input  wire logic        gpio_b7_oe,
  output logic             gpio_b7_in,
  // Serial port
  output logic             serial_receive_in,
  input  wire logic        serial_transmit_out,
  // Two-wire bus (open drain: drive low only when oe)
  output logic             twi_sda_in,
  input  wire logic        twi_sda_oe,
  output logic             twi_scl_in,
  input  wire logic        twi_scl_oe,
  // Clock module
  output logic             external_clock_input,
  // Analog routing enables
  output logic             conv_a_input2,
  output logic             conv_a_high_reference,
  output logic             conv_b_input0,
  output logic             comparator_b_input3,
  output logic             conv_b_input2,
  output logic             conv_b_high_reference,
  // Test port
  input  wire logic        tck,
  input  wire logic        tms,
  output logic             tap_trst_n,
  output logic             tap_in_reset
);

  // Registered select codes
  logic [1:0] s_b6;
  logic [1:0] s_b7;
  logic [1:0] s_c2;
  logic [1:0] s_c4;
  logic [1:0] s_c6;

  // Next values of the select registers
  logic [1:0] next_s_b6;
  logic [1:0] next_s_b7;
  logic [1:0] next_s_c2;
  logic [1:0] next_s_c4;
  logic [1:0] next_s_c6;

  // Test clock history and its rising edge
  logic       tck_q;
  logic       next_tck_q;
  logic       tck_rise;

  // Controller state, read back for the reset flag
  pbc_tap_e   tap_state;

  // Is this select code equal to the given peripheral choice of a C pad
  function automatic logic pick(input logic [1:0] s, input logic [1:0] code);
    pick = (s == code);
  endfunction

  // Select fields are registered so pads settle as GPIO out of reset
  always_comb
  begin
    next_s_b6 = sel_b6;
    next_s_b7 = sel_b7;
    next_s_c2 = sel_c2;
    next_s_c4 = sel_c4;
    next_s_c6 = sel_c6;
    next_tck_q = tck;
  end

  // Select and test clock history registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_b6  <= SEL_RESET;
      s_b7  <= SEL_RESET;
      s_c2  <= SEL_RESET;
      s_c4  <= SEL_RESET;
      s_c6  <= SEL_RESET;
      tck_q <= 1'b0;
    end
    else
    begin
      s_b6  <= next_s_b6;
      s_b7  <= next_s_b7;
      s_c2  <= next_s_c2;
      s_c4  <= next_s_c4;
      s_c6  <= next_s_c6;
      tck_q <= next_tck_q;
    end
  end

  // Pad B6 routing; unselected serial/bus inputs idle high, GPIO and clock inputs low
  always_comb
  begin
    // Pad released and peripheral inputs idle by default
    port_b_bit6_out      = 1'b0;
    port_b_bit6_oe       = 1'b0;
    port_b_bit6_an       = 1'b0;
    gpio_b6_in           = 1'b0;
    serial_receive_in    = 1'b1;
    twi_sda_in           = 1'b1;
    external_clock_input = 1'b0;
    case (s_b6)
      SEL_B6_GPIO:
      begin
        port_b_bit6_out = gpio_b6_out;
        port_b_bit6_oe  = gpio_b6_oe;
        gpio_b6_in      = port_b_bit6_in;
      end
      SEL_B6_RX:  serial_receive_in = port_b_bit6_in;
      // Open drain: pad only ever pulled low, never driven high
      SEL_B6_SDA:
      begin
        port_b_bit6_oe = twi_sda_oe;
        twi_sda_in     = port_b_bit6_in;
      end
      // Clock pad is passive until the clock module also enables it
      SEL_B6_CLK: external_clock_input = pll_external_clock_input_enable & port_b_bit6_in;
      default: ;
    endcase
  end

  // Pad B7 routing
  always_comb
  begin
    port_b_bit7_out = 1'b0;
    port_b_bit7_oe  = 1'b0;
    gpio_b7_in      = 1'b0;
    twi_scl_in      = 1'b1;
    case (s_b7)
      SEL_B7_GPIO:
      begin
        port_b_bit7_out = gpio_b7_out;
        port_b_bit7_oe  = gpio_b7_oe;
        gpio_b7_in      = port_b_bit7_in;
      end
      SEL_B7_TX:
      begin
        port_b_bit7_out = serial_transmit_out;
        port_b_bit7_oe  = 1'b1;
      end
      // Open drain as on the data line
      SEL_B7_SCL:
      begin
        port_b_bit7_oe = twi_scl_oe;
        twi_scl_in     = port_b_bit7_in;
      end
      default: ;
    endcase
  end

  // Analog switches: at most one per pad, none in GPIO or reserved code
  always_comb
  begin
    conv_a_input2         = pick(s_c2, SEL_C_FIRST);
    conv_a_high_reference = pick(s_c2, SEL_C_SECOND);
    conv_b_input0         = pick(s_c4, SEL_C_FIRST);
    comparator_b_input3   = pick(s_c4, SEL_C_SECOND);
    conv_b_input2         = pick(s_c6, SEL_C_FIRST);
    conv_b_high_reference = pick(s_c6, SEL_C_SECOND);
    // Pad switch closes when either function is picked
    port_c_bit2_an        = conv_a_input2 | conv_a_high_reference;
    port_c_bit4_an        = conv_b_input0 | comparator_b_input3;
    port_c_bit6_an        = conv_b_input2 | conv_b_high_reference;
  end

  // TCK sampled as a plain input; its rising edge steps the controller
  always_comb
  begin
    tck_rise     = tck & ~tck_q;
    // No reset pin: only power-on or TMS can reset the controller
    tap_trst_n   = 1'b1;
    tap_in_reset = (tap_state == PBC_TLR);
  end

  // TMS high on five edges always lands in TLR
  pbc_tap_fsm u_tap (
    .clock    (clock),
    .srst     (srst),
    .tck_rise (tck_rise),
    .tms      (tms),
    .state    (tap_state)
  );

endmodule

/* File: tb/pbc_pin_mux_props.sv */
module pbc_pin_mux_props
  import pbc_pkg::*;
(
  input wire logic       clock,
  input wire logic       srst,
  input wire logic [1:0] sel_b6,
  input wire logic [1:0] sel_b7,
  input wire logic [1:0] sel_c2,
  input wire logic [1:0] sel_c4,
  input wire logic [1:0] sel_c6,
  input wire logic       pll_external_clock_input_enable,
  input wire logic       port_b_bit6_in,
  input wire logic       port_b_bit7_out,
  input wire logic       port_b_bit7_oe,
  input wire logic       serial_receive_in,
  input wire logic       serial_transmit_out,
  input wire logic       twi_sda_in,
  input wire logic       external_clock_input,
  input wire logic       conv_a_input2,
  input wire logic       conv_a_high_reference,
  input wire logic       conv_b_input0,
  input wire logic       comparator_b_input3,
  input wire logic       conv_b_high_reference,
  input wire logic       tap_trst_n,
  input wire logic       twi_sda_oe,
  input wire logic       port_b_bit6_out,
  input wire logic       port_b_bit6_oe,
  input wire logic       twi_scl_oe,
  input wire logic       twi_scl_in,
  input wire logic       port_b_bit7_in,
  input wire logic       conv_b_input2,
  input wire logic       tap_in_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Selects act one cycle late; skip the edge right after reset
  rx_route_a: assert property (
    !$past(srst) && $past(sel_b6) == SEL_B6_RX |-> serial_receive_in == port_b_bit6_in)
    else $error("rx route");
  sda_drain_a: assert property (
    !$past(srst) && $past(sel_b6) == SEL_B6_SDA |-> !port_b_bit6_out
      && port_b_bit6_oe == twi_sda_oe && twi_sda_in == port_b_bit6_in)
    else $error("data line route");
  clk_gate_a: assert property (
    !$past(srst) && $past(sel_b6) == SEL_B6_CLK
      |-> external_clock_input == (port_b_bit6_in && pll_external_clock_input_enable))
    else $error("clock gate");
  tx_route_a: assert property (
    !$past(srst) && $past(sel_b7) == SEL_B7_TX
      |-> port_b_bit7_oe && port_b_bit7_out == serial_transmit_out)
    else $error("tx route");
  scl_drain_a: assert property (
    !$past(srst) && $past(sel_b7) == SEL_B7_SCL |-> !port_b_bit7_out
      && port_b_bit7_oe == twi_scl_oe && twi_scl_in == port_b_bit7_in)
    else $error("clock line route");
  c2_ref_a: assert property (
    !$past(srst) && $past(sel_c2) == SEL_C_SECOND |-> conv_a_high_reference && !conv_a_input2)
    else $error("c2 route");
  c4_conv_a: assert property (
    !$past(srst) && $past(sel_c4) == SEL_C_FIRST |-> conv_b_input0 && !comparator_b_input3)
    else $error("c4 route");
  c6_ref_a: assert property (
    !$past(srst) && $past(sel_c6) != SEL_C_SECOND |-> !conv_b_high_reference)
    else $error("c6 route");
  // Reset leaves every analog switch open
  reset_gpio_a: assert property (disable iff (1'b0)
    srst |=> !(conv_a_input2 || conv_a_high_reference || conv_b_input0
      || comparator_b_input3 || conv_b_input2 || conv_b_high_reference))
    else $error("analog switch closed after reset");
  trst_tied_a: assert property (tap_trst_n) else $error("test reset pin active");
  por_tap_a: assert property (disable iff (1'b0)
    srst |=> tap_in_reset)
    else $error("tap not reset");
  idle_in_a: assert property (
    !$past(srst) && $past(sel_b6) == SEL_B6_GPIO
      |-> serial_receive_in && twi_sda_in && !external_clock_input)
    else $error("idle level");
endmodule
bind pbc_pin_mux pbc_pin_mux_props u_props (.*);

/* File: tb/pbc_pads.sv */
module pbc_pads (
  input  wire logic pad6_out,
  input  wire logic pad6_oe,
  input  wire logic drive6,
  input  wire logic pad7_out,
  input  wire logic pad7_oe,
  input  wire logic drive7,
  output logic      pad6,
  output logic      pad7
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pad level: the block when it drives, else the outside driver
  assign pad6 = pad6_oe ? pad6_out : drive6;
  assign pad7 = pad7_oe ? pad7_out : drive7;
endmodule

/* File: tb/pbc_pin_mux_tb.sv */
module pbc_pin_mux_tb;
  import pbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, srst, pll_external_clock_input_enable, tck, tms, ext6, ext7, exp_tap;
  logic [1:0] sel_b6, sel_b7, sel_c2, sel_c4, sel_c6;
  logic gpio_b6_out, gpio_b6_oe, gpio_b7_out, gpio_b7_oe;
  logic serial_transmit_out, twi_sda_oe, twi_scl_oe;
  logic port_b_bit6_in, port_b_bit6_out, port_b_bit6_oe, port_b_bit6_an, port_b_bit7_in;
  logic port_b_bit7_out, port_b_bit7_oe, port_c_bit2_an, port_c_bit4_an, port_c_bit6_an;
  logic gpio_b6_in, gpio_b7_in, serial_receive_in, twi_sda_in, twi_scl_in, external_clock_input;
  logic conv_a_input2, conv_a_high_reference, conv_b_input0, comparator_b_input3;
  logic conv_b_input2, conv_b_high_reference, tap_trst_n, tap_in_reset;
  logic [31:0] seed;
  logic [21:0] q[$];
  int n_mismatch, samples_checked, cyc;
  event got;
  pbc_pin_mux u_pbc_pin_mux (.*);
  pbc_pads u_pbc_pads (.pad6_out(port_b_bit6_out), .pad6_oe(port_b_bit6_oe), .drive6(ext6),
    .pad7_out(port_b_bit7_out), .pad7_oe(port_b_bit7_oe), .drive7(ext7),
    .pad6(port_b_bit6_in), .pad7(port_b_bit7_in));
  initial
  begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected view from the select codes, the bench's inputs and the pad levels
  function automatic logic [21:0] expv();
    logic p6;
    logic p7;
    logic o6;
    logic o7;
    p6 = port_b_bit6_in;
    p7 = port_b_bit7_in;
    o6 = (sel_b6 == SEL_B6_GPIO) ? gpio_b6_oe : (sel_b6 == SEL_B6_SDA) && twi_sda_oe;
    o7 = (sel_b7 == SEL_B7_GPIO) ? gpio_b7_oe
      : (sel_b7 == SEL_B7_TX) || ((sel_b7 == SEL_B7_SCL) && twi_scl_oe);
    return {(sel_b6 == SEL_B6_RX) ? p6 : 1'b1, (sel_b6 == SEL_B6_SDA) ? p6 : 1'b1,
      (sel_b6 == SEL_B6_CLK) && p6 && pll_external_clock_input_enable, (sel_b6 == SEL_B6_GPIO) && p6, o6,
      (sel_b7 == SEL_B7_SCL) ? p7 : 1'b1, (sel_b7 == SEL_B7_GPIO) && p7, o7,
      sel_c2 == SEL_C_FIRST, sel_c2 == SEL_C_SECOND, sel_c4 == SEL_C_FIRST,
      sel_c4 == SEL_C_SECOND, sel_c6 == SEL_C_FIRST, sel_c6 == SEL_C_SECOND, exp_tap,
      (sel_b6 == SEL_B6_GPIO) && gpio_b6_out,
      (sel_b7 == SEL_B7_GPIO) ? gpio_b7_out : (sel_b7 == SEL_B7_TX) && serial_transmit_out,
      1'b0,
      (sel_c2 == SEL_C_FIRST) || (sel_c2 == SEL_C_SECOND),
      (sel_c4 == SEL_C_FIRST) || (sel_c4 == SEL_C_SECOND),
      (sel_c6 == SEL_C_FIRST) || (sel_c6 == SEL_C_SECOND),
      1'b1};
  endfunction
  task check();
    @(posedge clock);
    #2;
    q.push_back(expv());
    ->got;
  endtask
  // One test-clock pulse, each phase two cycles long
  task tck_rise(input logic v);
    @(negedge clock);
    tms = v;
    tck = 1;
    repeat (2) @(negedge clock);
    tck = 0;
    repeat (2) @(negedge clock);
  endtask
  task close_out();
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Monitor: compare outputs against the oldest note
  always @(got)
  begin
    logic [21:0] e, o;
    e = q.pop_front();
    o = {serial_receive_in, twi_sda_in, external_clock_input, gpio_b6_in, port_b_bit6_oe,
      twi_scl_in, gpio_b7_in, port_b_bit7_oe, conv_a_input2, conv_a_high_reference,
      conv_b_input0, comparator_b_input3, conv_b_input2, conv_b_high_reference, tap_in_reset,
      port_b_bit6_out, port_b_bit7_out, port_b_bit6_an, port_c_bit2_an, port_c_bit4_an,
      port_c_bit6_an, tap_trst_n};
    samples_checked++;
    if (o !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp %h got %h", $time, e, o);
    end
  end
  // Hang guard; the whole run needs under 1000 cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  initial
  begin
    {sel_b6, sel_b7, sel_c2, sel_c4, sel_c6, pll_external_clock_input_enable, tck, tms, ext6, ext7} = '0;
    {gpio_b6_out, gpio_b6_oe, gpio_b7_out, gpio_b7_oe, serial_transmit_out, twi_sda_oe} = '0;
    twi_scl_oe = 0;
    srst = 1;
    exp_tap = 1;
    seed = 32'h00017EDD;
    repeat (16) @(negedge clock);
    srst = 0;
    for (int i = 0; i < 64; i++)
    begin
      @(negedge clock);
      seed = lfsr(seed);
      {sel_b6, sel_b7, sel_c2} = 6'(i);
      sel_c4 = 2'(i >> 2);
      sel_c6 = 2'(i);
      {pll_external_clock_input_enable, gpio_b6_out, gpio_b6_oe, gpio_b7_out, gpio_b7_oe, serial_transmit_out,
        twi_sda_oe, twi_scl_oe, ext6, ext7} = seed[9:0];
      check();
    end
    $display("mux test done");
    tck_rise(0);
    exp_tap = 0;
    check();
    tck_rise(1);
    tck_rise(0);
    tck_rise(0);
    repeat (TAP_RESET_EDGES - 3'h1) tck_rise(1);
    check();
    tck_rise(1);
    exp_tap = 1;
    check();
    tck_rise(0);
    exp_tap = 0;
    check();
    @(negedge clock);
    srst = 1;
    @(negedge clock);
    srst = 0;
    exp_tap = 1;
    check();
    $display("test port done");
    close_out();
  end
endmodule
